// ==== bcseq_pkg.sv ====
// constants, state encoding and op codes of the instruction sequencer
package bcseq_pkg;
  // word and address geometry
  localparam int unsigned WORD_W      = 16;
  localparam int unsigned STACK_DEPTH = 8;
  localparam int unsigned OP_MSB      = 14;
  localparam int unsigned OP_LSB      = 10;
  localparam int unsigned CC_INV      = 4;
  localparam int unsigned GP_N        = 8;
  localparam int unsigned MSG_ST_N    = 7;
  // op code word layout and list stepping
  localparam logic [15:0] LIST_STEP   = 16'h0002;
  localparam logic [15:0] PRM_OFS     = 16'h0001;
  localparam logic [15:0] TNM_OFS     = 16'h0003;
  // condition code values
  localparam logic [3:0]  CC_ALWAYS   = 4'hF;
  localparam logic [3:0]  CC_TWO_RETRY = 4'hE;
  localparam logic [3:0]  CC_MSG_BASE = 4'h8;
  // pending interrupt register
  localparam logic [15:0] PEND_ADDR   = 16'h0007;
  localparam logic [15:0] PEND_RESET  = 16'h0000;
  localparam int unsigned PEND_REQ_LSB = 0;
  localparam int unsigned PEND_REQ_MSB = 3;
  localparam int unsigned PEND_CSTK    = 4;
  // op codes
  localparam logic [4:0]  OP_EXEC     = 5'h01;
  localparam logic [4:0]  OP_JUMP     = 5'h02;
  localparam logic [4:0]  OP_CALL     = 5'h03;
  localparam logic [4:0]  OP_RET      = 5'h04;
  localparam logic [4:0]  OP_IRQ      = 5'h06;
  localparam logic [4:0]  OP_HALT     = 5'h07;
  localparam logic [4:0]  OP_FLAG     = 5'h0A;
  localparam logic [4:0]  OP_MSG_CMP  = 5'h0B;
  localparam logic [4:0]  OP_FRM_CMP  = 5'h0C;
  localparam logic [4:0]  OP_EXEC_FLIP = 5'h0D;
  localparam logic [4:0]  OP_LD_TTAG  = 5'h10;
  localparam logic [4:0]  OP_LD_FT    = 5'h11;
  localparam logic [4:0]  OP_FRAME    = 5'h12;
  localparam logic [4:0]  OP_TRIG     = 5'h13;
  // sequencer states
  typedef enum logic [3:0] {
    ST_IDLE, ST_RD_OP, ST_WT_OP, ST_RD_PRM, ST_WT_PRM, ST_EXEC,
    ST_RD_TNM, ST_WT_TNM, ST_MSG, ST_HOLD, ST_TRIG
  } bcseq_state_t;
endpackage

// ==== bcseq_cond_eval.sv ====
// condition code evaluation for conditional op codes
`timescale 1ns/1ps
`default_nettype none
module bcseq_cond_eval (
  input  wire logic [4:0] i_code,
  input  wire logic [7:0] i_gp,
  input  wire logic [6:0] i_msg_status,
  output logic            o_true
);
  logic [3:0] sel;
  logic       inv;
  logic       base;
  logic [2:0] mi;

  // pick the tested flag, then apply the inversion bit
  always_comb begin
    sel  = i_code[3:0];
    inv  = i_code[bcseq_pkg::CC_INV];
    mi   = 3'(sel - bcseq_pkg::CC_MSG_BASE);
    base = 1'b0;
    if (sel < bcseq_pkg::CC_MSG_BASE) begin
      base = i_gp[sel[2:0]];             // gp flags, compare results share 0 and 1
    end else if (sel == bcseq_pkg::CC_ALWAYS) begin
      base = 1'b1;
    end else begin
      base = i_msg_status[mi];
    end
    o_true = base ^ inv;
    if (sel == bcseq_pkg::CC_TWO_RETRY && inv) begin
      o_true = 1'b0;                     // undefined code treated as false
    end
  end
endmodule
`default_nettype wire

// ==== bcseq_call_stack.sv ====
// return address stack with overflow and underflow detection
`timescale 1ns/1ps
`default_nettype none
module bcseq_call_stack #(
  parameter int unsigned DEPTH = bcseq_pkg::STACK_DEPTH
) (
  input  wire logic        i_ref_clk,
  input  wire logic        i_rstn,
  input  wire logic        i_ce,
  input  wire logic        i_push,
  input  wire logic        i_pop,
  input  wire logic [15:0] i_push_addr,
  output logic [15:0]      o_top,
  output logic             o_fault
);
  localparam int unsigned CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][15:0] mem;
    logic [CW-1:0]          cnt;
  } bcseq_stk_t;

  bcseq_stk_t r;
  bcseq_stk_t n;
  logic       over;
  logic       under;

  // eight nested levels, no change on error
  always_comb begin
    n     = r;
    over  = i_push && (r.cnt == FULL);
    under = i_pop && (r.cnt == '0);
    if (i_push && !over) begin
      n.mem[r.cnt] = i_push_addr;
      n.cnt        = r.cnt + CW'(1);
    end else if (i_pop && !under) begin
      n.cnt = r.cnt - CW'(1);
    end
  end

  assign o_fault = over || under;
  assign o_top   = (r.cnt == '0) ? 16'h0000 : r.mem[r.cnt - CW'(1)];

  // state register, frozen while the clock enable is low
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      r <= '0;
    end else if (i_ce) begin
      r <= n;
    end
  end

  a_push_full_hold: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (i_ce && i_push && r.cnt == FULL) |=> (r.cnt == FULL && $stable(r.mem)))
    else $error("stack changed on overflowing push");
endmodule
`default_nettype wire

// ==== bcseq_sequencer.sv ====
// bus controller instruction list fetch, decode and execute
// What this block does
// - op code is the 5-bit field in bits 14 to 10.
// - four op codes run without testing the condition code.
// - all other op codes run only when the condition is true.
// - a false condition moves the pointer to the next op code.
// - the word after each op code is fetched as its parameter.
// - message execute takes the parameter as control block address.
// - call stack nests return addresses eight levels deep.
// - stack overflow or underflow raises fault interrupt when enabled.
// - interrupt request writes 4-bit code to pending bits 3-0.
// - flag set/clear/toggle, time tag load, frame time load, frame start.
// - wait for trigger then frame start; frame and message time compares.
// - message execute is op code 0x01, else continue at next.
// - nonzero fourth block word loads and starts message countdown.
// - next op code waits until message countdown reaches zero.
// - compare outcomes change only when a compare, flag or flip op completes.
// - code 0xF is always, or never when bit 4 is set.
// - call, op code 0x03, pushes next address and jumps.
// - return, op code 0x04, pops and continues at popped address.
// - halt, op code 0x07, stops until a new start.
`timescale 1ns/1ps
`default_nettype none
module bcseq_sequencer (
  input  wire logic        i_ref_clk,
  input  wire logic        i_rstn,
  input  wire logic        i_ce,
  input  wire logic        i_bc_start,
  input  wire logic [15:0] i_list_base,
  output logic             o_running,
  output logic             o_ram_rd,
  output logic [15:0]      o_ram_addr,
  input  wire logic        i_ram_valid,
  input  wire logic [15:0] i_ram_rdata,
  output logic             o_msg_start,
  output logic [15:0]      o_msg_addr,
  input  wire logic        i_msg_done,
  input  wire logic [6:0]  i_msg_status,
  input  wire logic        i_tnm_tick,
  output logic [15:0]      o_tnm,
  input  wire logic [15:0] i_frame_time,
  output logic             o_frame_start,
  output logic             o_ttag_load,
  output logic             o_ft_load,
  output logic [15:0]      o_load_value,
  input  wire logic        i_ext_trigger,
  output logic [7:0]       o_gp_flags,
  input  wire logic        i_cstk_irq_en,
  input  wire logic        i_pend_rd,
  output logic [15:0]      o_pend_irq
);
  typedef struct packed {
    bcseq_pkg::bcseq_state_t st;
    logic [15:0] ptr;
    logic [15:0] rd_addr;
    logic [15:0] opw;
    logic [15:0] prm;
    logic [15:0] tnm;
    logic [7:0]  gp;
    logic [15:0] pend;
    logic        msg_start;
    logic        frame_start;
    logic        ttag_load;
    logic        ft_load;
    logic [15:0] load_val;
    logic [1:0]  trig_sync;
    logic        trig_prev;
  } bcseq_seq_t;

  bcseq_seq_t  r;
  bcseq_seq_t  n;
  logic [4:0]  op;
  logic        cc_true;
  logic        uncond;
  logic        go;
  logic        in_exec;
  logic        push;
  logic        pop;
  logic [15:0] nxt;
  logic [15:0] stk_top;
  logic        stk_fault;
  logic [7:0]  fs;
  logic [7:0]  fc;

  assign op      = r.opw[bcseq_pkg::OP_MSB:bcseq_pkg::OP_LSB];
  assign in_exec = (r.st == bcseq_pkg::ST_EXEC);
  assign nxt     = r.ptr + bcseq_pkg::LIST_STEP;
  assign uncond  = (op == bcseq_pkg::OP_MSG_CMP) || (op == bcseq_pkg::OP_FRM_CMP) ||
                   (op == bcseq_pkg::OP_FLAG) || (op == bcseq_pkg::OP_EXEC_FLIP);
  assign go      = uncond || cc_true;
  assign push    = in_exec && go && (op == bcseq_pkg::OP_CALL);
  assign pop     = in_exec && go && (op == bcseq_pkg::OP_RET);
  assign fs      = r.prm[7:0];
  assign fc      = r.prm[15:8];

  bcseq_cond_eval u_cond (
    .i_code       (r.opw[4:0]),
    .i_gp         (r.gp),
    .i_msg_status (i_msg_status),
    .o_true       (cc_true)
  );

  bcseq_call_stack #(
    .DEPTH (bcseq_pkg::STACK_DEPTH)
  ) u_stack (
    .i_ref_clk   (i_ref_clk),
    .i_rstn      (i_rstn),
    .i_ce        (i_ce),
    .i_push      (push),
    .i_pop       (pop),
    .i_push_addr (nxt),
    .o_top       (stk_top),
    .o_fault     (stk_fault)
  );

  // next state of the sequencer
  always_comb begin
    n             = r;
    n.msg_start   = 1'b0;
    n.frame_start = 1'b0;
    n.ttag_load   = 1'b0;
    n.ft_load     = 1'b0;
    n.trig_sync   = {r.trig_sync[0], i_ext_trigger};
    n.trig_prev   = r.trig_sync[1];
    if (i_tnm_tick && r.tnm != 16'h0000) begin
      n.tnm = r.tnm - 16'h0001;             // message countdown
    end
    if (i_pend_rd) begin
      n.pend = bcseq_pkg::PEND_RESET;       // read clears, later sets win
    end
    if (stk_fault && i_cstk_irq_en) begin
      n.pend[bcseq_pkg::PEND_CSTK] = 1'b1;
    end
    case (r.st)
      bcseq_pkg::ST_IDLE: begin
        if (i_bc_start) begin
          n.ptr     = i_list_base;
          n.rd_addr = i_list_base;
          n.st      = bcseq_pkg::ST_RD_OP;
        end
      end
      bcseq_pkg::ST_RD_OP: n.st = bcseq_pkg::ST_WT_OP;
      bcseq_pkg::ST_WT_OP: begin
        if (i_ram_valid) begin
          n.opw     = i_ram_rdata;
          n.rd_addr = r.ptr + bcseq_pkg::PRM_OFS;
          n.st      = bcseq_pkg::ST_RD_PRM;
        end
      end
      bcseq_pkg::ST_RD_PRM: n.st = bcseq_pkg::ST_WT_PRM;
      bcseq_pkg::ST_WT_PRM: begin
        if (i_ram_valid) begin
          n.prm = i_ram_rdata;
          n.st  = bcseq_pkg::ST_EXEC;
        end
      end
      bcseq_pkg::ST_EXEC: begin
        // default advance past op code and parameter
        n.ptr     = nxt;
        n.rd_addr = nxt;
        n.st      = bcseq_pkg::ST_RD_OP;
        if (go) begin
          case (op)
            // message execute reads block word four
            bcseq_pkg::OP_EXEC, bcseq_pkg::OP_EXEC_FLIP: begin
              n.rd_addr = r.prm + bcseq_pkg::TNM_OFS;
              n.st      = bcseq_pkg::ST_RD_TNM;
              if (op == bcseq_pkg::OP_EXEC_FLIP) begin
                n.gp[r.opw[2:0]] = ~r.gp[r.opw[2:0]];
              end
            end
            bcseq_pkg::OP_JUMP: begin
              n.ptr     = r.prm;
              n.rd_addr = r.prm;
            end
            // call jumps unless the push faulted
            bcseq_pkg::OP_CALL: begin
              if (!stk_fault) begin
                n.ptr     = r.prm;
                n.rd_addr = r.prm;
              end
            end
            bcseq_pkg::OP_RET: begin
              if (!stk_fault) begin
                n.ptr     = stk_top;
                n.rd_addr = stk_top;
              end
            end
            bcseq_pkg::OP_IRQ: begin
              if (r.prm[3:0] != 4'h0) begin
                n.pend[bcseq_pkg::PEND_REQ_MSB:bcseq_pkg::PEND_REQ_LSB] = r.prm[3:0];
              end
            end
            bcseq_pkg::OP_HALT: n.st = bcseq_pkg::ST_IDLE;
            // flag set, clear, toggle when both
            bcseq_pkg::OP_FLAG: n.gp = ((r.gp | fs) & ~fc) | (~r.gp & fs & fc);
            // compare results land in flags 0 and 1
            bcseq_pkg::OP_MSG_CMP: begin
              n.gp[0] = (r.tnm < r.prm);
              n.gp[1] = (r.tnm == r.prm);
            end
            bcseq_pkg::OP_FRM_CMP: begin
              n.gp[0] = (i_frame_time < r.prm);
              n.gp[1] = (i_frame_time == r.prm);
            end
            bcseq_pkg::OP_LD_TTAG: begin
              n.ttag_load = 1'b1;
              n.load_val  = r.prm;
            end
            bcseq_pkg::OP_LD_FT: begin
              n.ft_load  = 1'b1;
              n.load_val = r.prm;
            end
            bcseq_pkg::OP_FRAME: n.frame_start = 1'b1;
            bcseq_pkg::OP_TRIG: n.st = bcseq_pkg::ST_TRIG;
            default: ;
          endcase
        end
      end
      bcseq_pkg::ST_RD_TNM: n.st = bcseq_pkg::ST_WT_TNM;
      bcseq_pkg::ST_WT_TNM: begin
        if (i_ram_valid) begin
          if (i_ram_rdata != 16'h0000) begin
            n.tnm = i_ram_rdata;
          end
          n.msg_start = 1'b1;
          n.st        = bcseq_pkg::ST_MSG;
        end
      end
      bcseq_pkg::ST_MSG: begin
        if (i_msg_done) begin
          n.st = bcseq_pkg::ST_HOLD;
        end
      end
      // hold fetch until countdown is zero
      bcseq_pkg::ST_HOLD: begin
        if (r.tnm == 16'h0000) begin
          n.rd_addr = r.ptr;
          n.st      = bcseq_pkg::ST_RD_OP;
        end
      end
      bcseq_pkg::ST_TRIG: begin
        if (r.trig_sync[1] && !r.trig_prev) begin
          n.frame_start = 1'b1;
          n.st          = bcseq_pkg::ST_RD_OP;
        end
      end
      default: n.st = bcseq_pkg::ST_IDLE;
    endcase
  end

  // state register, frozen while the clock enable is low
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      r <= '0;
    end else if (i_ce) begin
      r <= n;
    end
  end

  // outputs
  assign o_running     = (r.st != bcseq_pkg::ST_IDLE);
  assign o_ram_rd      = (r.st == bcseq_pkg::ST_RD_OP) || (r.st == bcseq_pkg::ST_RD_PRM) ||
                         (r.st == bcseq_pkg::ST_RD_TNM);
  assign o_ram_addr    = r.rd_addr;
  // control block address is the parameter
  assign o_msg_addr    = r.prm;
  assign o_msg_start   = r.msg_start;
  assign o_tnm         = r.tnm;
  assign o_frame_start = r.frame_start;
  assign o_ttag_load   = r.ttag_load;
  assign o_ft_load     = r.ft_load;
  assign o_load_value  = r.load_val;
  assign o_gp_flags    = r.gp;
  assign o_pend_irq    = r.pend;

  a_skip_false_step: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (i_ce && in_exec && !go) |=> (r.ptr == $past(r.ptr) + 16'h0002 && o_ram_rd))
    else $error("false condition did not skip two words");

  a_msg_cmp_result: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (i_ce && in_exec && op == bcseq_pkg::OP_MSG_CMP)
    |=> (r.gp[1] == ($past(r.tnm) == $past(r.prm))))
    else $error("message time compare result wrong");

  a_cmp_stable: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (!in_exec || !i_ce) |=> $stable(r.gp))
    else $error("flags changed outside an op code");

  a_exec_block_rd: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (i_ce && in_exec && cc_true && op == bcseq_pkg::OP_EXEC)
    |=> (o_ram_rd && o_ram_addr == $past(r.prm) + 16'h0003))
    else $error("block word four not fetched");

  a_tnm_hold: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (r.st == bcseq_pkg::ST_HOLD && r.tnm != 16'h0000) |=> !o_ram_rd)
    else $error("fetch before countdown ended");

  a_irq_code: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (i_ce && in_exec && cc_true && op == bcseq_pkg::OP_IRQ && r.prm[3:0] != 4'h0)
    |=> (o_pend_irq[3:0] == $past(r.prm[3:0])))
    else $error("interrupt code not posted");

  a_cstk_report: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (i_ce && stk_fault && i_cstk_irq_en) |=> o_pend_irq[bcseq_pkg::PEND_CSTK])
    else $error("stack fault not reported");

  a_halt_stop: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (i_ce && in_exec && cc_true && op == bcseq_pkg::OP_HALT) |=> !o_running)
    else $error("halt did not stop");

  a_call_jump: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (i_ce && push && !stk_fault) |=> (r.ptr == $past(r.prm)))
    else $error("call did not jump");

  a_never_code: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (r.opw[4:0] == 5'h1F) |-> !cc_true)
    else $error("never code tested true");
endmodule
`default_nettype wire

// ==== bcseq_ram_model.sv ====
// memory and message engine standing in for the far side of the sequencer
`timescale 1ns/1ps
`default_nettype none
module bcseq_ram_model (
  input  wire logic        i_ref_clk,
  input  wire logic        i_ram_rd,
  input  wire logic [15:0] i_ram_addr,
  output logic             o_ram_valid,
  output logic [15:0]      o_ram_rdata,
  input  wire logic        i_msg_start,
  output logic             o_msg_done,
  output logic             o_tnm_tick
);
  logic [15:0] mem [0:1023];
  logic [15:0] addr_r;
  int          rd_cnt;
  int          msg_cnt;
  int          mseed;
  // idle values at time zero
  initial begin
    mseed = 5;
    rd_cnt = 0;
    msg_cnt = 0;
    o_ram_valid = 1'b0;
    o_ram_rdata = 16'h0000;
    o_msg_done = 1'b0;
    o_tnm_tick = 1'b0;
  end
  // reads answer after 1 to 3 cycles; data lines churn while not valid
  always @(negedge i_ref_clk) begin
    o_ram_valid <= 1'b0;
    o_ram_rdata <= ~o_ram_rdata;
    o_msg_done <= 1'b0;
    o_tnm_tick <= ~o_tnm_tick;
    if (i_ram_rd === 1'b1) begin
      addr_r = i_ram_addr;
      rd_cnt = 1 + $unsigned($random(mseed)) % 3;
    end else if (rd_cnt > 0) begin
      if (rd_cnt == 1) begin
        o_ram_valid <= 1'b1;
        o_ram_rdata <= mem[addr_r[9:0]];
      end
      rd_cnt--;
    end
    // message transaction lasts a random number of cycles
    if (i_msg_start === 1'b1) begin
      msg_cnt = 2 + $unsigned($random(mseed)) % 20;
    end
    if (msg_cnt > 0) begin
      if (msg_cnt == 1) begin
        o_msg_done <= 1'b1;
      end
      msg_cnt--;
    end
  end
endmodule
`default_nettype wire

// ==== bcseq_sequencer_bench.sv ====
// self-checking bench for the instruction sequencer
`timescale 1ns/1ps
`default_nettype none
module bcseq_sequencer_bench;
  logic        i_ref_clk, i_rstn, i_bc_start, i_cstk_irq_en, i_pend_rd;
  logic [15:0] i_list_base, i_frame_time, ram_rdata;
  logic [6:0]  i_msg_status;
  logic        o_running, o_ram_rd, ram_valid, o_msg_start, msg_done, tnm_tick, o_ttag_load;
  logic [15:0] o_ram_addr, o_msg_addr, o_tnm, o_load_value, o_pend_irq;
  logic [7:0]  o_gp_flags, gp;
  logic [15:0] fp, cp, code, exp_blk, exp_tnm, exp_ld;
  logic [4:0]  icc;
  logic        hit, xq;
  int          seed = 98987;
  int          errors = 0;
  int          checked = 0;
  int          msgs, lds;
  logic        ce, trig, o_frame_start, o_ft_load;
  int          frs, fts;

  bcseq_sequencer bcseq_sequencer_i (.i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_ce(ce),
    .i_bc_start(i_bc_start), .i_list_base(i_list_base), .o_running(o_running),
    .o_ram_rd(o_ram_rd), .o_ram_addr(o_ram_addr), .i_ram_valid(ram_valid),
    .i_ram_rdata(ram_rdata), .o_msg_start(o_msg_start), .o_msg_addr(o_msg_addr),
    .i_msg_done(msg_done), .i_msg_status(i_msg_status), .i_tnm_tick(tnm_tick),
    .o_tnm(o_tnm), .i_frame_time(i_frame_time), .o_frame_start(o_frame_start),
    .o_ttag_load(o_ttag_load), .o_ft_load(o_ft_load), .o_load_value(o_load_value),
    .i_ext_trigger(trig), .o_gp_flags(o_gp_flags),
    .i_cstk_irq_en(i_cstk_irq_en), .i_pend_rd(i_pend_rd), .o_pend_irq(o_pend_irq));

  bcseq_ram_model bcseq_ram_model_i (.i_ref_clk(i_ref_clk), .i_ram_rd(o_ram_rd),
    .i_ram_addr(o_ram_addr), .o_ram_valid(ram_valid), .o_ram_rdata(ram_rdata),
    .i_msg_start(o_msg_start), .o_msg_done(msg_done), .o_tnm_tick(tnm_tick));

  // 125 MHz clock
  initial i_ref_clk = 1'b0;
  always #4 i_ref_clk = ~i_ref_clk;

  function automatic logic [15:0] rnd(input int n);
    return 16'($unsigned($random(seed)) % n);
  endfunction
  // expected flags after a set/clear/toggle parameter
  function automatic logic [7:0] flag_nx(input logic [7:0] g, input logic [15:0] p);
    return (g & ~p[15:8] & ~p[7:0]) | (p[7:0] & ~p[15:8]) | (~g & p[7:0] & p[15:8]);
  endfunction
  // expected outcome of a condition code test
  function automatic logic cc_exp(input logic [7:0] g, input logic [6:0] s,
                                  input logic [4:0] c);
    logic b;
    if (c[3:0] == 4'hF)
      b = 1'b1;
    else if (c[3])
      b = s[c[2:0]];
    else
      b = g[c[2:0]];
    return (c[3:0] == 4'hE && c[4]) ? 1'b0 : (b ^ c[4]);
  endfunction
  task automatic chk(input logic ok, input string msg);
    checked++;
    if (ok !== 1'b1) begin
      errors++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask
  // op code word with its parameter word
  task automatic put2(input logic [15:0] a, input logic [4:0] op, input logic [4:0] cc,
                      input logic [15:0] p);
    bcseq_ram_model_i.mem[a[9:0]] = {1'b0, op, 5'h00, cc};
    bcseq_ram_model_i.mem[a[9:0] + 10'h001] = p;
  endtask
  task automatic pclear;
    @(negedge i_ref_clk);
    i_pend_rd = 1'b1;
    @(negedge i_ref_clk);
    i_pend_rd = 1'b0;
    chk(o_pend_irq === 16'h0000, "pending not cleared by read");
  endtask
  task automatic run(input logic [15:0] base);
    int n;
    @(negedge i_ref_clk);
    i_bc_start = 1'b1;
    i_list_base = base;
    @(negedge i_ref_clk);
    i_bc_start = 1'b0;
    n = 0;
    while (o_running !== 1'b0 && n < 3000) begin
      @(negedge i_ref_clk);
      n++;
    end
    chk(n < 3000, "list did not halt");
  endtask
  task automatic give_verdict;
    $display("errors=%0d checked=%0d", errors, checked);
    if (errors == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // watch message starts, time tag loads and fetch hold-off
  always @(negedge i_ref_clk) begin
    if (i_rstn === 1'b1 && o_ram_rd === 1'b1)
      chk(o_tnm === 16'h0000, "op fetch during countdown");
    if (o_msg_start === 1'b1) begin
      msgs++;
      chk(o_msg_addr === exp_blk, "message block address");
      chk(o_tnm === exp_tnm || o_tnm + 16'h0001 === exp_tnm, "countdown load");
    end
    if (o_ttag_load === 1'b1) begin
      lds++;
      chk(o_load_value === exp_ld, "time tag load value");
    end
    if (o_ft_load === 1'b1) begin
      fts++;
      chk(o_load_value === exp_ld, "frame time load value");
    end
    if (o_frame_start === 1'b1)
      frs++;
  end

  // watchdog
  initial begin
    repeat (40000) @(posedge i_ref_clk);
    errors++;
    $display("[ERR] %0t watchdog expired", $time);
    give_verdict();
  end

  // main sequence
  initial begin
    i_rstn = 1'b0;
    i_bc_start = 1'b0;
    i_list_base = 16'h0000;
    i_cstk_irq_en = 1'b0;
    i_pend_rd = 1'b0;
    ce = 1'b1;
    trig = 1'b0;
    i_frame_time = 16'h0000;
    i_msg_status = 7'h00;
    exp_blk = 16'h0200;
    exp_tnm = 16'h0000;
    exp_ld = 16'h0000;
    gp = 8'h00;
    repeat (8) @(negedge i_ref_clk);
    chk(o_pend_irq === 16'h0000 && o_gp_flags === 8'h00 && o_running === 1'b0, "reset");
    i_rstn = 1'b1;
    for (int it = 0; it < 8; it++) begin
      fp = rnd(65536);
      cp = rnd(65536);
      code = 16'(1 + rnd(15));
      icc = (it == 2) ? 5'h1F : (it == 3) ? 5'h0F : 5'(rnd(32));
      gp = flag_nx(gp, fp);
      i_frame_time = (it == 0) ? cp : rnd(65536);
      i_msg_status = 7'(rnd(128));
      hit = cc_exp(gp, i_msg_status, icc);
      gp[1:0] = {i_frame_time == cp, i_frame_time < cp};
      exp_tnm = (it == 1) ? 16'h0000 : 16'(1 + rnd(24));
      exp_ld = rnd(65536);
      xq = (it != 4);
      put2(16'h0010, bcseq_pkg::OP_FLAG, 5'h1F, fp);
      put2(16'h0012, bcseq_pkg::OP_IRQ, icc, code);
      put2(16'h0014, bcseq_pkg::OP_FRM_CMP, 5'h1F, cp);
      put2(16'h0016, bcseq_pkg::OP_EXEC, xq ? 5'h0F : 5'h1F, exp_blk);
      put2(16'h0018, bcseq_pkg::OP_CALL, 5'h0F, 16'h0080);
      put2(16'h001A, bcseq_pkg::OP_HALT, 5'h0F, rnd(65536));
      put2(16'h0080, bcseq_pkg::OP_LD_TTAG, 5'h0F, exp_ld);
      put2(16'h0082, bcseq_pkg::OP_RET, 5'h0F, rnd(65536));
      bcseq_ram_model_i.mem[10'h203] = exp_tnm;
      pclear();
      msgs = 0;
      lds = 0;
      run(16'h0010);
      chk(o_gp_flags === gp, "flag and compare result");
      chk(o_pend_irq === (hit ? code : 16'h0000), "interrupt request code");
      chk(msgs == (xq ? 1 : 0), "message execute count");
      chk(lds == 1, "subroutine call and return");
    end
    // clock enable low freezes a pending start
    ce = 1'b0;
    i_bc_start = 1'b1;
    i_list_base = 16'h0100;
    repeat (3) @(negedge i_ref_clk);
    chk(o_running === 1'b0, "start taken while frozen");
    i_bc_start = 1'b0;
    ce = 1'b1;
    // loads, frame starts, trigger wait, message compare, flip and jump
    cp = rnd(2);
    put2(16'h0100, bcseq_pkg::OP_LD_FT, 5'h0F, exp_ld);
    put2(16'h0102, bcseq_pkg::OP_FRAME, 5'h0F, 16'h0000);
    put2(16'h0104, bcseq_pkg::OP_TRIG, 5'h0F, 16'h0000);
    put2(16'h0106, bcseq_pkg::OP_MSG_CMP, 5'h1F, cp);
    put2(16'h0108, bcseq_pkg::OP_EXEC_FLIP, 5'h15, exp_blk);
    put2(16'h010A, bcseq_pkg::OP_JUMP, 5'h0F, 16'h010E);
    put2(16'h010C, bcseq_pkg::OP_LD_TTAG, 5'h0F, exp_ld);
    put2(16'h010E, bcseq_pkg::OP_HALT, 5'h0F, 16'h0000);
    gp[1:0] = {cp == 16'h0000, cp != 16'h0000};
    gp[5] = ~gp[5];
    msgs = 0;
    lds = 0;
    frs = 0;
    fts = 0;
    fork
      run(16'h0100);
      begin
        @(posedge o_frame_start);
        repeat (20) @(negedge i_ref_clk);
        trig = 1'b1;
      end
    join
    chk(o_gp_flags === gp, "message compare and flip");
    chk(msgs == 1 && lds == 0, "flip message and jump");
    chk(frs == 2 && fts == 1, "frame starts and frame time load");
    // call stack faults and depth
    i_cstk_irq_en = 1'b1;
    put2(16'h0300, bcseq_pkg::OP_RET, 5'h0F, 16'h0000);
    put2(16'h0302, bcseq_pkg::OP_HALT, 5'h0F, 16'h0000);
    pclear();
    run(16'h0300);
    chk(o_pend_irq === 16'h0010, "underflow fault");
    put2(16'h0310, bcseq_pkg::OP_CALL, 5'h0F, 16'h0310);
    put2(16'h0312, bcseq_pkg::OP_HALT, 5'h0F, 16'h0000);
    for (int i = 0; i < 2; i++) begin
      i_cstk_irq_en = (i == 1);
      pclear();
      run(16'h0310);
      chk(o_pend_irq === {11'h000, i == 1, 4'h0}, "overflow fault enable");
    end
    for (int i = 0; i < 9; i++) begin
      pclear();
      run(16'h0300);
      chk(o_pend_irq === {11'h000, i == 8, 4'h0}, "stack depth after fault");
    end
    give_verdict();
  end
endmodule
`default_nettype wire
